// >>> core/sci_char_timing.sv
// Character timing of the serial interface: holding buffer, framed
// transmit shifter, mid-bit receiver and receive buffer handover.
// Assumes all inputs are synchronous to clk, the bus phase clock.
`timescale 1ns/100ps
// Behaviour
// - Data write loads holding buffer until shifter free
// - Transfer adds start and stop bits
// - Transfer pulse one cycle after Tx clock rise
// - Buffer-empty flag sets two cycles after transfer pulse
// - Stop bit completes before new character starts
// - Empty buffer gives no transfer pulse
// - Idle writes transfer at next Tx clock rise
// - Disable finishes character, then complete, release pin
// - Bit boundaries on Tx clock falling edges
// - Receiver samples each bit near middle
// - Full flag sets at end of stop bit
// - Received character handed over at stop end
// - Enable sends 10 or 11 bit idle preamble
// - Enable recognised at next Tx clock fall
module sci_char_timing (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Software side, transmit
  input wire logic serial_data_wr,
  input wire logic [8:0] serial_data_wdata,
  input wire logic tx_enable_bit,
  input wire logic nine_bit_mode,
  output logic tx_buffer_empty_flag,
  output logic tx_complete_flag,
  // Software side, receive
  output sci_char_timing_pkg::rx_word_type rx_holding_buffer,
  output logic rx_buffer_full_flag,
  input wire logic rx_read,
  output logic rx_overrun,
  // Serial pins
  output logic txd_out,
  output logic txd_oe_n,
  input wire logic rxd_in
);

  typedef enum logic {TX_OFF, TX_ON} tx_state_type;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP}
    rx_state_type;

  // Free-running Tx clock divider
  logic [3:0] div_reg, div_next;
  logic tx_rise, tx_fall;

  always_comb begin
    div_next = div_reg + 4'h1;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      div_reg <= sci_char_timing_pkg::CNT_ZERO;
    end else begin
      div_reg <= div_next;
    end
  end

  // Rise at mid bit, fall at every bit boundary
  assign tx_rise = (div_reg == sci_char_timing_pkg::CNT_MID);
  assign tx_fall = (div_reg == sci_char_timing_pkg::CNT_LAST);

  // Transmit state
  tx_state_type tx_state_reg, tx_state_next;
  logic [8:0] holding_reg, holding_next;
  logic holding_full_reg, holding_full_next;
  logic xfer_reg, xfer_next;
  logic tx_buffer_empty_flag_reg, tx_buffer_empty_flag_next;
  logic tc_reg, tc_next;
  logic [10:0] shift_reg, shift_next;
  logic [3:0] bits_left_reg, bits_left_next;
  logic line_reg, line_next;

  always_comb begin
    tx_state_next = tx_state_reg;
    holding_next = holding_reg;
    holding_full_next = holding_full_reg;
    tx_buffer_empty_flag_next = tx_buffer_empty_flag_reg;
    tc_next = tc_reg;
    shift_next = shift_reg;
    bits_left_next = bits_left_reg;
    line_next = line_reg;
    // Pulse only when data waits and the shifter is on its last bit
    xfer_next = tx_rise && holding_full_reg
      && (bits_left_reg == sci_char_timing_pkg::CNT_ZERO)
      && (tx_state_reg == TX_ON) && tx_enable_bit;
    if (xfer_reg) begin
      holding_full_next = 1'b0;
      bits_left_next = nine_bit_mode ? sci_char_timing_pkg::FRAME_BITS_9
        : sci_char_timing_pkg::FRAME_BITS_8;
      // Loaded while the stop bit still drives the line
      shift_next = nine_bit_mode ? {1'b1, holding_reg, 1'b0}
        : {2'b11, holding_reg[7:0], 1'b0};
      tx_buffer_empty_flag_next = 1'b0;
    end
    // Write clears flags; below, only a complete set with tx_enable_bit low can override it
    if (serial_data_wr) begin
      holding_next = serial_data_wdata;
      holding_full_next = 1'b1;
      tx_buffer_empty_flag_next = 1'b0;
      tc_next = 1'b0;
    end
    if (tx_buffer_empty_flag_reg == 1'b0 && !holding_full_reg && !xfer_reg
        && !serial_data_wr) begin
      tx_buffer_empty_flag_next = 1'b1;
    end
    unique case (tx_state_reg)
      TX_OFF: begin
        line_next = 1'b1;
        if (tx_fall && tx_enable_bit) begin
          tx_state_next = TX_ON;
          shift_next = sci_char_timing_pkg::SHIFT_IDLE;
          bits_left_next = nine_bit_mode
            ? sci_char_timing_pkg::PREAMBLE_BITS_9
            : sci_char_timing_pkg::PREAMBLE_BITS_8;
        end
      end
      TX_ON: begin
        if (tx_fall) begin
          if (bits_left_reg != sci_char_timing_pkg::CNT_ZERO) begin
            line_next = shift_reg[0];
            shift_next = {1'b1, shift_reg[10:1]};
            bits_left_next = bits_left_reg - 4'h1;
          end else begin
            line_next = 1'b1;
            // No completion while a character still waits to go, unless tx_enable_bit is low
            if (!holding_full_next || !tx_enable_bit) begin
              tc_next = 1'b1;
            end
            if (!tx_enable_bit) begin
              tx_state_next = TX_OFF;
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_state_reg <= TX_OFF;
      holding_reg <= sci_char_timing_pkg::DATA_RESET;
      holding_full_reg <= 1'b0;
      xfer_reg <= 1'b0;
      tx_buffer_empty_flag_reg <= 1'b1;
      tc_reg <= 1'b1;
      shift_reg <= sci_char_timing_pkg::SHIFT_IDLE;
      bits_left_reg <= sci_char_timing_pkg::CNT_ZERO;
      line_reg <= 1'b1;
    end else begin
      tx_state_reg <= tx_state_next;
      holding_reg <= holding_next;
      holding_full_reg <= holding_full_next;
      xfer_reg <= xfer_next;
      tx_buffer_empty_flag_reg <= tx_buffer_empty_flag_next;
      tc_reg <= tc_next;
      shift_reg <= shift_next;
      bits_left_reg <= bits_left_next;
      line_reg <= line_next;
    end
  end

  assign tx_buffer_empty_flag = tx_buffer_empty_flag_reg;
  assign tx_complete_flag = tc_reg;
  assign txd_out = line_reg;
  assign txd_oe_n = (tx_state_reg != TX_ON);

  // Receive state
  rx_state_type rx_state_reg, rx_state_next;
  logic [3:0] rx_cnt_reg, rx_cnt_next;
  logic [3:0] rx_bit_reg, rx_bit_next;
  logic [8:0] rx_shift_reg, rx_shift_next;
  logic rx_ferr_reg, rx_ferr_next;
  logic rxd_prev_reg;
  logic overrun_reg, overrun_next;
  logic rx_push_n;
  logic fifo_ready;
  sci_char_timing_pkg::rx_word_type rx_word;

  always_comb begin
    rx_state_next = rx_state_reg;
    rx_cnt_next = rx_cnt_reg + 4'h1;
    rx_bit_next = rx_bit_reg;
    rx_shift_next = rx_shift_reg;
    rx_ferr_next = rx_ferr_reg;
    overrun_next = overrun_reg && !rx_read;
    rx_push_n = 1'b1;
    unique case (rx_state_reg)
      RX_IDLE: begin
        rx_cnt_next = sci_char_timing_pkg::CNT_ZERO;
        // Falling edge starts perceived bit timing
        if (rxd_prev_reg && !rxd_in) begin
          rx_state_next = RX_START;
        end
      end
      RX_START: begin
        if (rx_cnt_reg == sci_char_timing_pkg::CNT_MID && rxd_in) begin
          rx_state_next = RX_IDLE; // Glitch, not a start bit
        end else if (rx_cnt_reg == sci_char_timing_pkg::CNT_LAST) begin
          rx_state_next = RX_DATA;
          rx_bit_next = sci_char_timing_pkg::CNT_ZERO;
        end
      end
      RX_DATA: begin
        if (rx_cnt_reg == sci_char_timing_pkg::CNT_MID) begin
          rx_shift_next = {rxd_in, rx_shift_reg[8:1]};
        end
        if (rx_cnt_reg == sci_char_timing_pkg::CNT_LAST) begin
          rx_bit_next = rx_bit_reg + 4'h1;
          if (rx_bit_reg == (nine_bit_mode
              ? sci_char_timing_pkg::DATA_LAST_9
              : sci_char_timing_pkg::DATA_LAST_8)) begin
            rx_state_next = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        if (rx_cnt_reg == sci_char_timing_pkg::CNT_MID) begin
          rx_ferr_next = !rxd_in;
        end
        if (rx_cnt_reg == sci_char_timing_pkg::CNT_LAST) begin
          rx_state_next = RX_IDLE;
          rx_push_n = 1'b0;
          // Line cannot be stalled, so a full buffer drops the word
          if (!fifo_ready) begin
            overrun_next = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_state_reg <= RX_IDLE;
      rx_cnt_reg <= sci_char_timing_pkg::CNT_ZERO;
      rx_bit_reg <= sci_char_timing_pkg::CNT_ZERO;
      rx_shift_reg <= sci_char_timing_pkg::DATA_RESET;
      rx_ferr_reg <= 1'b0;
      rxd_prev_reg <= 1'b1;
      overrun_reg <= 1'b0;
    end else begin
      rx_state_reg <= rx_state_next;
      rx_cnt_reg <= rx_cnt_next;
      rx_bit_reg <= rx_bit_next;
      rx_shift_reg <= rx_shift_next;
      rx_ferr_reg <= rx_ferr_next;
      rxd_prev_reg <= rxd_in;
      overrun_reg <= overrun_next;
    end
  end

  // Stop sample is used directly since the flag lands at the same edge
  always_comb begin
    rx_word.data = nine_bit_mode ? rx_shift_reg
      : {1'b0, rx_shift_reg[8:1]};
    rx_word.frame_error = rx_ferr_next;
  end

  sci_pair_buffer rx_buffer (
    .clk(clk),
    .reset_n(reset_n),
    .in_valid(!rx_push_n),
    .in_ready(fifo_ready),
    .in_word(rx_word),
    .out_valid(rx_buffer_full_flag),
    .out_ready(rx_read),
    .out_word(rx_holding_buffer)
  );

  assign rx_overrun = overrun_reg;

endmodule : sci_char_timing

// >>> include/sci_char_timing_pkg.sv
// Constants and carrier types for the serial character timing block.
// Assumes the bus phase clock is the single system clock of the block.
package sci_char_timing_pkg;

  // Bus phase cycles per bit time; the Tx clock is derived from this
  localparam int BIT_CYCLES = 16;
  localparam logic [3:0] CNT_LAST = 4'hf;
  localparam logic [3:0] CNT_MID = 4'h7;
  localparam logic [3:0] CNT_ZERO = 4'h0;

  // Frame and preamble lengths in bit times, and index of the last data bit
  localparam logic [3:0] PREAMBLE_BITS_8 = 4'ha;
  localparam logic [3:0] PREAMBLE_BITS_9 = 4'hb;
  localparam logic [3:0] FRAME_BITS_8 = 4'ha;
  localparam logic [3:0] FRAME_BITS_9 = 4'hb;
  localparam logic [3:0] DATA_LAST_8 = 4'h7;
  localparam logic [3:0] DATA_LAST_9 = 4'h8;

  // Shift register images
  localparam logic [10:0] SHIFT_IDLE = 11'h7ff;
  localparam logic [8:0] DATA_RESET = 9'h000;

  // Receive buffer depth
  localparam int BUF_DEPTH = 2;

  typedef struct packed {
    logic [8:0] data;
    logic frame_error;
  } rx_word_type;

endpackage : sci_char_timing_pkg

// >>> core/sci_pair_buffer.sv
// Two-entry receive buffer with valid and ready on both sides.
// Assumes one clock; storage is flip-flops addressed by an index.
`timescale 1ns/100ps
module sci_pair_buffer (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire sci_char_timing_pkg::rx_word_type in_word,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output sci_char_timing_pkg::rx_word_type out_word
);

  sci_char_timing_pkg::rx_word_type mem_reg [sci_char_timing_pkg::BUF_DEPTH];
  sci_char_timing_pkg::rx_word_type mem_next [sci_char_timing_pkg::BUF_DEPTH];
  logic wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic [1:0] count_reg, count_next;
  logic push, pop;

  assign in_ready = (count_reg != 2'h2);
  assign out_valid = (count_reg != 2'h0);
  assign out_word = mem_reg[rd_ptr_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    mem_next = mem_reg;
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    count_next = count_reg;
    if (push) begin
      mem_next[wr_ptr_reg] = in_word;
      wr_ptr_next = !wr_ptr_reg;
    end
    if (pop) begin
      rd_ptr_next = !rd_ptr_reg;
    end
    if (push && !pop) begin
      count_next = count_reg + 2'h1;
    end else if (pop && !push) begin
      count_next = count_reg - 2'h1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < sci_char_timing_pkg::BUF_DEPTH; i++) begin
        mem_reg[i] <= '0;
      end
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg <= 2'h0;
    end else begin
      mem_reg <= mem_next;
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg <= count_next;
    end
  end

endmodule : sci_pair_buffer

// >>> test/sci_char_timing_properties.sv
// Port checker for the serial character timing block.
// Assumes the bit divider restarts at zero with reset.
`timescale 1ns/100ps
module sci_char_timing_properties (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Transmit side
  input wire logic serial_data_wr,
  input wire logic tx_buffer_empty_flag,
  input wire logic tx_complete_flag,
  input wire logic txd_out,
  input wire logic txd_oe_n,
  // Receive side
  input wire logic rx_buffer_full_flag,
  input wire logic rx_read,
  input wire logic rxd_in
);
  // Divider copy; reads zero in the cycle after a boundary
  logic [3:0] phase_reg;
  logic [3:0] phase_next;
  always_comb phase_next = phase_reg + 4'h1;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      phase_reg <= 4'h0;
    end else begin
      phase_reg <= phase_next;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  AST_TXD_BOUNDARY: assert property (
    phase_reg != 4'h0 |-> $stable(txd_out))
    else $error("txd moved off a boundary");
  AST_OE_BOUNDARY: assert property (
    phase_reg != 4'h0 |-> $stable(txd_oe_n))
    else $error("pin ownership moved off a boundary");
  AST_PIN_IDLE_HIGH: assert property (txd_oe_n |-> txd_out)
    else $error("txd low while pin released");
  AST_WRITE_FILLS: assert property (
    serial_data_wr |=> !tx_buffer_empty_flag)
    else $error("write left buffer empty");
  AST_COMPLETE_BUSY: assert property (
    !txd_oe_n && !txd_out |-> !tx_complete_flag)
    else $error("complete flag set during a frame");
  AST_EMPTY_HOLDS: assert property (
    tx_buffer_empty_flag && !serial_data_wr |=> tx_buffer_empty_flag)
    else $error("empty flag fell without write");
  AST_EMPTY_SET_TIME: assert property (
    $rose(tx_buffer_empty_flag) |-> phase_reg inside {4'h9, 4'ha})
    else $error("empty flag set at wrong phase");
  AST_COMPLETE_RELEASE: assert property (
    $rose(txd_oe_n) |-> tx_complete_flag && phase_reg == 4'h0)
    else $error("pin released without completion");
  AST_RX_STOP_END: assert property (
    $rose(rx_buffer_full_flag) |-> $past(rxd_in, 3) && $past(rxd_in, 12))
    else $error("full flag before stop bit end");
  AST_FULL_HOLDS: assert property (
    rx_buffer_full_flag && !rx_read |=> rx_buffer_full_flag)
    else $error("full flag dropped without read");
  cover property ($rose(tx_buffer_empty_flag));
  cover property ($rose(txd_oe_n));
  cover property (rx_buffer_full_flag && rx_read);
endmodule : sci_char_timing_properties

// >>> test/sci_serial_partner.sv
// Remote serial partner: takes frames off txd, sends frames on rxd.
// Assumes 16 clk per bit and the block's word length setting.
`timescale 1ns/100ps
module sci_serial_partner (
  // Clock and word length
  input wire logic clk,
  input wire logic nine_bit_mode,
  // Line from the block
  input wire logic txd_out,
  input wire logic txd_oe_n,
  // Line to the block
  output logic rxd_in
);
  // Taken frames as {stop, data}; idle line is a driven mark level
  logic [9:0] got_q[$];
  // Released pin is pulled up, so only an owned line can start a frame
  logic pin_level;
  assign pin_level = txd_oe_n ? 1'b1 : txd_out;
  initial rxd_in = 1'b1;
  task automatic send(input logic [8:0] v);
    logic [10:0] f;
    int i;
    f = nine_bit_mode ? {1'b1, v, 1'b0} : {2'b11, v[7:0], 1'b0};
    @(posedge clk);
    #1;
    for (i = 0; i < (nine_bit_mode ? 11 : 10); i++) begin
      rxd_in = f[i];
      repeat (16) @(posedge clk);
      #1;
    end
  endtask : send
  always begin : take
    logic [9:0] s;
    int i;
    @(negedge pin_level);
    s = 10'h3ff;
    repeat (8) @(posedge clk);
    for (i = 0; i < (nine_bit_mode ? 10 : 9); i++) begin
      repeat (16) @(posedge clk);
      s[i] = pin_level;
    end
    got_q.push_back(nine_bit_mode ? s : {s[8], 1'b0, s[7:0]});
  end
endmodule : sci_serial_partner

// >>> test/testbench.sv
// Self-checking bench for the serial character timing block.
// Assumes the partner model closes both serial lines at 16 clk per bit.
`timescale 1ns/100ps
module testbench;
  logic clk, reset_n, serial_data_wr, tx_enable_bit, nine_bit_mode;
  logic tx_buffer_empty_flag, tx_complete_flag, rx_buffer_full_flag;
  logic rx_read, rx_overrun, txd_out, txd_oe_n, rxd_in;
  logic [8:0] serial_data_wdata;
  logic overwrite;
  sci_char_timing_pkg::rx_word_type rx_holding_buffer;
  logic [9:0] exp_q[$];
  logic [8:0] d[3];
  integer seed;
  int mismatches, compares, a;
  initial clk = 1'b0;
  always #5 clk = ~clk;
  sci_char_timing i_dut (.clk, .reset_n, .serial_data_wr, .serial_data_wdata,
    .tx_enable_bit, .nine_bit_mode, .tx_buffer_empty_flag, .tx_complete_flag,
    .rx_holding_buffer, .rx_buffer_full_flag, .rx_read, .rx_overrun,
    .txd_out, .txd_oe_n, .rxd_in);
  sci_serial_partner i_partner (.clk, .nine_bit_mode, .txd_out, .txd_oe_n,
    .rxd_in);
  function automatic logic [8:0] exp_data(input logic [8:0] v);
    return nine_bit_mode ? v : {1'b0, v[7:0]};
  endfunction : exp_data
  task automatic check(input logic [9:0] got, input logic [9:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %h, expected %h", $time, got, exp);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic wait_low(input int lim);
    for (a = 0; a < lim && txd_out !== 1'b0; a++) tick(1);
  endtask : wait_low
  // Waits up to 400 ticks for room, then writes anyway, so a write can land on a full buffer
  task automatic write_char(input logic [8:0] v);
    tick(1);
    for (a = 0; a < 400 && tx_buffer_empty_flag !== 1'b1; a++) tick(1);
    if (!overwrite) check({9'h0, tx_buffer_empty_flag}, 10'h1);
    serial_data_wr = 1'b1;
    serial_data_wdata = v;
    tick(1);
    serial_data_wr = 1'b0;
    exp_q.push_back({1'b1, exp_data(v)});
  endtask : write_char
  task automatic enable_and_time(input int lo, input int hi);
    write_char(9'($random(seed)));
    tx_enable_bit = 1'b1;
    for (a = 0; a < 40 && txd_oe_n !== 1'b0; a++) tick(1);
    wait_low(300);
    check({9'h0, a >= lo && a <= hi}, 10'h1);
  endtask : enable_and_time
  task automatic drain_tx;
    for (a = 0; a < 4000 && i_partner.got_q.size() < exp_q.size(); a++)
      tick(1);
    tick(12);
    check({9'h0, tx_complete_flag}, 10'h1);
    while (exp_q.size() > 0 && i_partner.got_q.size() > 0)
      check(i_partner.got_q.pop_front(), exp_q.pop_front());
    check(10'(exp_q.size() + i_partner.got_q.size()), 10'h0);
  endtask : drain_tx
  task automatic read_rx(input logic [8:0] v);
    tick(1);
    for (a = 0; a < 400 && rx_buffer_full_flag !== 1'b1; a++) tick(1);
    check({9'h0, rx_buffer_full_flag}, 10'h1);
    check(rx_holding_buffer, {exp_data(v), 1'b0});
    rx_read = 1'b1;
    tick(1);
    rx_read = 1'b0;
  endtask : read_rx
  task automatic final_report;
    if (mismatches == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report
  initial begin : watchdog
    #500000;
    mismatches++;
    final_report;
  end
  initial begin : main
    seed = 32'hd9329fee;
    {reset_n, serial_data_wr, tx_enable_bit, nine_bit_mode, rx_read} = 5'h0;
    serial_data_wdata = 9'h000;
    overwrite = 1'b0;
    tick(5);
    check({4'h0, tx_buffer_empty_flag, tx_complete_flag,
      rx_buffer_full_flag, rx_overrun, txd_out, txd_oe_n}, 10'h033);
    reset_n = 1'b1;
    enable_and_time(160, 176);
    for (int i = 0; i < 4; i++) write_char(9'($random(seed)));
    drain_tx;
    // Disable in first cycle of start bit: the frame must still finish
    write_char(9'h0ff);
    wait_low(300);
    tx_enable_bit = 1'b0;
    drain_tx;
    check({9'h0, txd_oe_n}, 10'h1);
    write_char(9'h155);
    void'(exp_q.pop_back());
    tick(400);
    check(10'(i_partner.got_q.size()), 10'h0);
    nine_bit_mode = 1'b1;
    // Held character stays unsent, so this write overwrites it
    overwrite = 1'b1;
    enable_and_time(176, 192);
    overwrite = 1'b0;
    drain_tx;
    write_char(9'h1ff);
    wait_low(40);
    check({9'h0, a < 40}, 10'h1);
    for (int i = 0; i < 2; i++) write_char(9'($random(seed)));
    drain_tx;
    // Three frames unread: the third overflows the two-entry buffer
    for (int i = 0; i < 3; i++) begin
      d[i] = 9'($random(seed));
      i_partner.send(d[i]);
    end
    tick(4);
    check({8'h0, rx_overrun, rx_buffer_full_flag}, 10'h3);
    read_rx(d[0]);
    read_rx(d[1]);
    tick(1);
    check({8'h0, rx_overrun, rx_buffer_full_flag}, 10'h0);
    nine_bit_mode = 1'b0;
    i_partner.send(9'h1a5);
    read_rx(9'h1a5);
    final_report;
  end
endmodule : testbench
bind sci_char_timing sci_char_timing_properties i_props (.clk, .reset_n,
  .serial_data_wr, .tx_buffer_empty_flag, .tx_complete_flag, .txd_out,
  .txd_oe_n, .rx_buffer_full_flag, .rx_read, .rxd_in);
